// ### pmlt_defs.vh
// constants for the pci master latency timeout block
`ifndef PMLT_DEFS_VH
`define PMLT_DEFS_VH
`define PMLT_OFS_SETTING 4'h0
`define PMLT_OFS_STATUS 4'h4
`define PMLT_OFS_MASK 4'h8
`define PMLT_OFS_COUNT 4'hC
`define PMLT_SETTING_RESET 5'h00
`define PMLT_FIELD_MSB 4
`define PMLT_ST_ABORT 0
`define PMLT_ST_RETRY 1
`endif

// ### pmlt_timeout.v
// pci master transaction timeout counter with avalon-mm register slave
`timescale 1ns/1ps
`include "pmlt_defs.vh"
// Functional notes
// RULE_01: a zero timeout field disables the timeout; no abort results.
// RULE_02: nonzero field loads as upper five bits of an eight-bit counter.
// RULE_03: counter restarts from start value on every valid data transfer.
// RULE_04: expiry before target ready terminates transaction with master abort.
// RULE_05: timeout abort also drives the system error output active.
// RULE_06: endless target retries are ended by master abort on expiry.
// RULE_07: counter advances per clock while waiting; idle without master cycle.
module pmlt_timeout (
   input wire ref_clk,
   input wire nrst,
   input wire [3:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWriteData,
   output reg [31:0] avsReadData,
   output wire avsWaitRequest,
   input wire masterActive,
   input wire targetReadyN,
   input wire targetRetry,
   output reg masterAbort,
   output reg systemErrorN,
   output wire irq
);

   // programmed timeout field and interrupt registers
   reg [4:0] masterTimeoutValue_q;
   reg [1:0] status_q;
   reg [1:0] status_d;
   reg [1:0] mask_q;
   reg readDone_q;
   // timeout counter
   reg [7:0] count_q;
   reg [7:0] count_d;
   // master cycle tracking
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;
   reg [1:0] cycle_q;
   reg [1:0] cycle_d;
   // two-stage synchronisers for master active, target ready and retry
   reg [2:0] actSync1_q;
   reg [2:0] actSync2_q;
   wire act;
   wire trdyN;
   wire retry;
   wire [7:0] startValue;
   wire enabled;
   wire expire;
   wire readLaunch;
   wire settingWrite;
   wire maskWrite;
   wire statusWrite;
   wire [1:0] wrClear;
   wire [1:0] statusSet;

   // address decode shared by the write strobes and the read mux
   function addrHit;
      input [3:0] addr;
      input [3:0] ofs;
      begin
         addrHit = (addr == ofs);
      end
   endfunction

   // a set in the same cycle as a clear wins, so no event is lost
   function [1:0] stickyNext;
      input [1:0] current;
      input [1:0] set;
      input [1:0] clear;
      begin
         stickyNext = set | (current & ~clear);
      end
   endfunction

   // unmapped offsets read as zero
   function [31:0] readMux;
      input [3:0] addr;
      input [4:0] setting;
      input [1:0] status;
      input [1:0] mask;
      input [7:0] count;
      begin
         readMux = 32'h0000_0000;
         if (addrHit(addr, `PMLT_OFS_SETTING))
            readMux = {27'h0000000, setting};
         if (addrHit(addr, `PMLT_OFS_STATUS))
            readMux = {30'h0000000, status};
         if (addrHit(addr, `PMLT_OFS_MASK))
            readMux = {30'h0000000, mask};
         if (addrHit(addr, `PMLT_OFS_COUNT))
            readMux = {24'h000000, count};
      end
   endfunction

   // pin levels are read only behind the second flip-flop
   assign act = actSync2_q[0];
   assign trdyN = actSync2_q[1];
   assign retry = actSync2_q[2];

   // one wait state on reads so read data comes from a flip-flop
   assign readLaunch = avsRead & ~readDone_q;
   assign avsWaitRequest = readLaunch;
   assign settingWrite = avsWrite & addrHit(avsAddress, `PMLT_OFS_SETTING);
   assign maskWrite = avsWrite & addrHit(avsAddress, `PMLT_OFS_MASK);
   assign statusWrite = avsWrite & addrHit(avsAddress, `PMLT_OFS_STATUS);
   assign wrClear = statusWrite ? avsWriteData[1:0] : 2'h0;

   assign startValue = {masterTimeoutValue_q, 3'h0}; // RULE_02
   assign enabled = (masterTimeoutValue_q != 5'h00); // RULE_01
   assign expire = enabled & act & trdyN & (count_q == 8'h00) & (cycle_q == ST_WAIT); // RULE_04
   assign statusSet = {expire & retry, expire}; // RULE_06
   assign irq = |(status_q & mask_q);

   // idle levels: no master cycle, target ready deasserted, no retry
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         actSync1_q <= 3'h2;
         actSync2_q <= 3'h2;
      end else begin
         actSync1_q <= {targetRetry, targetReadyN, masterActive};
         actSync2_q <= actSync1_q;
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         masterTimeoutValue_q <= `PMLT_SETTING_RESET;
      end else if (settingWrite) begin
         masterTimeoutValue_q <= avsWriteData[`PMLT_FIELD_MSB:0]; // RULE_02
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= 2'h0;
      end else if (maskWrite) begin
         mask_q <= avsWriteData[1:0];
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         readDone_q <= 1'b0;
         avsReadData <= 32'h0000_0000;
      end else begin
         readDone_q <= readLaunch;
         if (readLaunch) begin
            avsReadData <= readMux(avsAddress, masterTimeoutValue_q,
                                   status_q, mask_q, count_q);
         end
      end
   end

   always @* begin
      status_d = stickyNext(status_q, statusSet, wrClear);
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= 2'h0;
      end else begin
         status_q <= status_d;
      end
   end

   // after an abort the cycle is over: no second abort until the master goes idle
   always @* begin
      cycle_d = cycle_q;
      case (cycle_q)
         ST_IDLE: begin
            if (act) begin
               cycle_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!act) begin
               cycle_d = ST_IDLE;
            end else if (expire) begin
               cycle_d = ST_DONE; // RULE_06
            end
         end
         ST_DONE: begin
            if (!act) begin
               cycle_d = ST_IDLE;
            end
         end
         default: begin
            cycle_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cycle_q <= ST_IDLE;
      end else begin
         cycle_q <= cycle_d;
      end
   end

   // a zero field keeps the counter parked at its start value
   always @* begin
      count_d = count_q;
      if (!act || !enabled || cycle_q == ST_DONE) begin
         count_d = startValue; // RULE_07
      end else if (!trdyN) begin
         count_d = startValue; // RULE_03
      end else if (count_q != 8'h00) begin
         count_d = count_q - 8'h01; // RULE_07
      end else begin
         count_d = startValue; // RULE_06
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= 8'h00;
      end else begin
         count_q <= count_d;
      end
   end

   // abort and error are one-cycle pulses launched from the same expiry
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         masterAbort <= 1'b0;
      end else begin
         masterAbort <= expire; // RULE_04 RULE_06
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         systemErrorN <= 1'b1;
      end else begin
         systemErrorN <= ~expire; // RULE_05
      end
   end
endmodule

// ### pmlt_props.sv
// assertion checker for the timeout block
`timescale 1ns/1ps
module pmlt_props (
   input wire ref_clk,
   input wire nrst,
   input wire avsRead,
   input wire avsWrite,
   input wire avsWaitRequest,
   input wire masterActive,
   input wire targetReadyN,
   input wire masterAbort,
   input wire systemErrorN,
   input wire irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_one;
      masterAbort |=> !masterAbort;
   endproperty
   a_one: assert property (p_one) else $error("abort held");
   property p_se;
      masterAbort |-> !systemErrorN;
   endproperty
   a_se: assert property (p_se) else $error("no serr");
   property p_se_only;
      !systemErrorN |-> masterAbort;
   endproperty
   a_se_only: assert property (p_se_only) else $error("serr without abort");
   property p_act;
      masterAbort |-> $past(masterActive, 3);
   endproperty
   a_act: assert property (p_act) else $error("abort without master cycle");
   property p_trdy;
      masterAbort |-> $past(targetReadyN, 3);
   endproperty
   a_trdy: assert property (p_trdy) else $error("abort although target ready");
   property p_wr_fast;
      avsWrite |-> !avsWaitRequest;
   endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_rd_wait;
      $rose(avsRead) |-> avsWaitRequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read without wait state");
   c_abort: cover property (masterAbort);
   c_irq: cover property (irq);
   c_read: cover property (avsRead && !avsWaitRequest);
endmodule

// ### pmlt_target.sv
// target model answering master cycles
`timescale 1ns/1ps
module pmlt_target (
   input wire ref_clk,
   input wire masterActive,
   input wire fast,
   input wire retryMode,
   output reg targetReadyN = 1'b1,
   output reg targetRetry = 1'b0
);
   // a fast target completes a data phase every second clock, a slow one never
   always @(posedge ref_clk) begin
      targetReadyN <= !(masterActive && fast && targetReadyN);
      targetRetry <= masterActive && retryMode;
   end
endmodule

// ### tb_top.sv
// self-checking bench for the timeout block
`timescale 1ns/1ps
module tb_top;
   reg ref_clk = 1'b0;
   reg nrst = 1'b0;
   reg avsRead = 1'b0;
   reg avsWrite = 1'b0;
   reg masterActive = 1'b0;
   reg fast = 1'b0;
   reg retryMode = 1'b0;
   reg [3:0] avsAddress = 4'h0;
   reg [31:0] avsWriteData = 32'h0000_0000;
   wire [31:0] avsReadData;
   wire avsWaitRequest;
   wire targetReadyN;
   wire targetRetry;
   wire masterAbort;
   wire systemErrorN;
   wire irq;
   integer n_mismatch = 0;
   integer comparisons = 0;
   integer ab = 0;
   integer b;
   integer v;
   reg [31:0] expQ[$];
   pmlt_timeout uut (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .avsAddress(avsAddress),
      .avsRead(avsRead),
      .avsWrite(avsWrite),
      .avsWriteData(avsWriteData),
      .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest),
      .masterActive(masterActive),
      .targetReadyN(targetReadyN),
      .targetRetry(targetRetry),
      .masterAbort(masterAbort),
      .systemErrorN(systemErrorN),
      .irq(irq)
   );
   pmlt_target tgt (
      .ref_clk(ref_clk),
      .masterActive(masterActive),
      .fast(fast),
      .retryMode(retryMode),
      .targetReadyN(targetReadyN),
      .targetRetry(targetRetry)
   );
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // aborts and serr pulses counted together, so each abort adds two
   always @(posedge ref_clk) begin
      ab <= ab + masterAbort + !systemErrorN;
   end
   task ck(input [31:0] s, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t %h %h", $time, s, e);
         end
      end
   endtask
   // read data is checked against the oldest note as the read completes
   always @(posedge ref_clk) begin
      if (avsRead && !avsWaitRequest) begin
         ck(avsReadData, expQ.pop_front());
      end
   end
   task bus(input w, input [3:0] a, input [31:0] d);
      begin
         if (!w) expQ.push_back(d);
         avsWrite <= w;
         avsRead <= !w;
         avsAddress <= a;
         avsWriteData <= d;
         @(posedge ref_clk iff !avsWaitRequest);
         avsWrite <= 1'b0;
         avsRead <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   // ST_DONE blocks a second expiry until the master goes idle, so one abort at most
   task run(input f, input r, input [31:0] e);
      begin
         fast <= f;
         retryMode <= r;
         masterActive <= 1'b1;
         b = ab;
         repeat (v * 8 + 9) @(posedge ref_clk);
         masterActive <= 1'b0;
         repeat (6) @(posedge ref_clk);
         ck(ab - b, e);
         $display("done");
      end
   endtask
   task end_sim;
      begin
         $display("%0d checks %0d mismatches", comparisons, n_mismatch);
         if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // the scenarios need well under a thousand cycles; this only catches a hang
   initial begin
      #20000;
      n_mismatch = n_mismatch + 1;
      end_sim;
   end
   initial begin
      v = $urandom(32'hCF7B) % 3 + 1;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      bus(1'b1, 4'h0, v);
      bus(1'b0, 4'h0, v);
      bus(1'b0, 4'hC, v * 8);
      bus(1'b1, 4'h8, 32'h1);
      run(1'b0, 1'b0, 32'h2);
      ck(irq, 32'h1);
      bus(1'b1, 4'h4, 32'h1);
      run(1'b1, 1'b0, 32'h0);
      run(1'b0, 1'b1, 32'h2);
      bus(1'b0, 4'h4, 32'h3);
      bus(1'b1, 4'h4, 32'h3);
      ck(irq, 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      run(1'b0, 1'b0, 32'h0);
      end_sim;
   end
endmodule
bind pmlt_timeout pmlt_props prp (
   .ref_clk(ref_clk),
   .nrst(nrst),
   .avsRead(avsRead),
   .avsWrite(avsWrite),
   .avsWaitRequest(avsWaitRequest),
   .masterActive(masterActive),
   .targetReadyN(targetReadyN),
   .masterAbort(masterAbort),
   .systemErrorN(systemErrorN),
   .irq(irq)
);
